// ===== src/audio_ctrl_pkg.sv
// package: register map, field positions, reset values and timing for the audio control bank
package audio_ctrl_pkg;
   localparam logic [3:0]  ADDR_CLICK      = 4'h4;  // keyclick/mono/soft-step control
   localparam logic [3:0]  ADDR_POWER      = 4'h5;  // audio power / misc control
   localparam logic [3:0]  ADDR_VOLUME     = 4'h8;  // volume target and mute (own map)
   localparam logic [3:0]  ADDR_STATUS     = 4'h9;  // live status (own map)
   // keyclick register fields
   localparam int          CK_TRIG_BIT     = 15;
   localparam int          CK_AMP_LSB      = 12;
   localparam int          CK_FREQ_LSB     = 8;
   localparam int          CK_LEN_LSB      = 4;
   localparam int          CK_MONO_BIT     = 2;
   localparam int          CK_RATE_BIT     = 1;
   localparam int          CK_SSDONE_BIT   = 0;
   localparam logic [2:0]  CK_AMP_RST      = 3'h4;
   localparam logic [2:0]  CK_FREQ_RST     = 3'h4;
   localparam logic [3:0]  CK_LEN_RST      = 4'h1;
   // power register fields
   localparam int          PW_MASTER_BIT   = 15;
   localparam int          PW_VCM_BIT      = 14;
   localparam int          PW_BYPASS_BIT   = 13;
   localparam int          PW_HP_BIT       = 12;
   localparam int          PW_MONO_BIT     = 11;
   localparam int          PW_DAC_BIT      = 10;
   localparam int          PW_ADC_BIT      = 9;
   localparam int          PW_DONE_BIT     = 7;
   localparam int          PW_MICB_BIT     = 6;
   localparam int          PW_OSC_BIT      = 5;
   localparam int          PW_CLKBUF_BIT   = 4;
   localparam int          PW_SMON_BIT     = 3;
   localparam int          PW_UNSYNC_BIT   = 2;
   localparam int          PW_BASS_BIT     = 1;
   localparam int          PW_DEEMP_BIT    = 0;
   localparam logic [7:0]  PW_HIGH_RST     = 8'hFF;
   localparam logic [15:0] PW_WMASK        = 16'hFF7B; // bits 7 and 2 read-only
   // volume register fields
   localparam int          VOL_MUTE_BIT    = 15;
   localparam logic [6:0]  VOL_RST         = 7'h7F;
   // timing
   localparam int          CLK_HZ          = 200_000_000;
   localparam int          STEP_US         = 20;
   localparam int          STEP_CYC        = STEP_US * (CLK_HZ / 1_000_000);
   localparam int          VCM_RAMP_MS     = 500;
   localparam int          VCM_RAMP_CYC    = VCM_RAMP_MS * (CLK_HZ / 1000);
   localparam int          SECTION_US      = 10;
   localparam int          SECTION_CYC     = SECTION_US * (CLK_HZ / 1_000_000);
   localparam int          HALF_BASE_HZ    = 125;  // half period base: 62.5 Hz tone
   // one half period of the 62.5 Hz tone is 1/125 s
   localparam int          HALF_BASE_CYC   = CLK_HZ / HALF_BASE_HZ;
endpackage

// ===== src/audio_keyclick_power_control.sv
// register bank with keyclick generator, soft-step engine and power sequencing
`timescale 1ns/1ps
`default_nettype none
module audio_keyclick_power_control
   import audio_ctrl_pkg::*;
#(
   parameter int VCM_RAMP_CYCLES = VCM_RAMP_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        bus_unsync_in,
   output logic             click_active,
   output logic             click_wave,
   output logic [2:0]       click_amplitude,
   output logic             mono_source_select,
   output logic [6:0]       gain_level,
   output logic             gain_zero_out,
   output logic [6:0]       section_power_on,
   output logic             common_mode_reference,
   output logic             mic_bias_on,
   output logic             crystal_osc_on,
   output logic             osc_clock_buffer_on,
   output logic             sync_monitor_on,
   output logic             converters_halted,
   output logic             bass_filter_on,
   output logic             deemphasis_on
);
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACK  = 3'b010,
      BUS_DONE = 3'b100
   } bus_state_e;

   bus_state_e  bus_reg;
   logic [15:0] click_reg;
   logic [15:0] power_reg;
   logic [7:0]  volume_reg;
   logic        softstep_done_flag;
   logic        power_sequence_done_flag;
   logic        serial_audio_unsync_flag;
   logic [1:0]  unsync_sync_reg;
   logic [15:0] wdata;
   logic        wr_hit;
   logic        rd_hit;
   logic [15:0] click_rd;
   logic [15:0] power_rd;

   assign wdata  = avs_writedata[15:0];
   assign wr_hit = (bus_reg == BUS_ACK) && avs_write;
   assign rd_hit = (bus_reg == BUS_ACK) && avs_read;
   // keyclick reserved bits 11 and 3 forced low on read
   assign click_rd = {click_reg[15:12], 1'b0, click_reg[10:4], 1'b0, click_reg[2:1],
                      softstep_done_flag};
   assign power_rd = {power_reg[15:8], power_sequence_done_flag, power_reg[6:3],
                      serial_audio_unsync_flag, power_reg[1:0]};

   // one wait cycle then acknowledge; keeps write decode off the raw request
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_reg <= BUS_IDLE;
      end else begin
         case (bus_reg)
            BUS_IDLE: if (avs_read || avs_write) bus_reg <= BUS_ACK;
            BUS_ACK:  bus_reg <= BUS_DONE;
            BUS_DONE: bus_reg <= BUS_IDLE;
            default:  bus_reg <= BUS_IDLE;
         endcase
      end
   end

   assign avs_waitrequest = (bus_reg != BUS_ACK);

   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h0;
      end else if (rd_hit || (bus_reg == BUS_IDLE && avs_read)) begin
         case (avs_address)
            ADDR_CLICK:  avs_readdata <= {16'h0, click_rd};
            ADDR_POWER:  avs_readdata <= {16'h0, power_rd};
            ADDR_VOLUME: avs_readdata <= {24'h0, volume_reg};
            ADDR_STATUS: avs_readdata <= {29'h0, click_active, gain_zero_out,
                                          converters_halted};
            default:     avs_readdata <= 32'h0;
         endcase
      end
   end

   // ---------------- keyclick generator ----------------
   logic [23:0] half_cnt;
   logic [23:0] half_len;
   logic [5:0]  half_left;
   logic        click_end;

   assign half_len  = 24'(HALF_BASE_CYC) >> click_reg[CK_FREQ_LSB +: 3];
   assign click_end = click_active && (half_cnt == 24'h1) && (half_left == 6'h1);

   always_ff @(posedge clk) begin
      if (srst) begin
         click_reg <= {1'b0, CK_AMP_RST, 1'b0, CK_FREQ_RST, CK_LEN_RST, 4'h0};
      end else begin
         if (wr_hit && avs_address == ADDR_CLICK) begin
            if (avs_byteenable[1]) click_reg[15:8] <= {wdata[15:12], 1'b0, wdata[10:8]};
            if (avs_byteenable[0]) click_reg[7:0]  <= {wdata[7:4], 1'b0, wdata[2:1], 1'b0};
         end else if (click_end) begin
            click_reg[CK_TRIG_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         click_active <= 1'b0;
         click_wave   <= 1'b0;
         half_cnt     <= 24'h0;
         half_left    <= 6'h0;
      end else if (!click_active && click_reg[CK_TRIG_BIT]) begin
         click_active <= 1'b1;
         click_wave   <= 1'b1;
         half_cnt     <= half_len;
         // (len+1)*2 periods = (len+1)*4 half periods
         // length 15 wraps to zero, which the down-count treats as 64 halves
         half_left    <= {4'(click_reg[CK_LEN_LSB +: 4] + 4'h1), 2'b00};
      end else if (click_active) begin
         if (half_cnt == 24'h1) begin
            half_cnt   <= half_len;
            click_wave <= ~click_wave;
            half_left  <= half_left - 6'h1;
            if (half_left == 6'h1) begin
               click_active <= 1'b0;
               click_wave   <= 1'b0;
            end
         end else begin
            half_cnt <= half_cnt - 24'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         click_amplitude    <= CK_AMP_RST;
         mono_source_select <= 1'b0;
      end else begin
         click_amplitude    <= click_reg[CK_AMP_LSB +: 3];
         mono_source_select <= click_reg[CK_MONO_BIT];
      end
   end

   // ---------------- volume soft-step ----------------
   logic [11:0] step_cnt;
   logic        step_half;
   logic        step_tick;
   logic [6:0]  gain_target;

   assign gain_target = volume_reg[VOL_MUTE_BIT - 8] ? 7'h0 : volume_reg[6:0];

   always_ff @(posedge clk) begin
      if (srst) begin
         step_cnt  <= 12'h0;
         step_half <= 1'b0;
         step_tick <= 1'b0;
      end else begin
         step_tick <= 1'b0;
         if (step_cnt == 12'(STEP_CYC - 1)) begin
            step_cnt  <= 12'h0;
            step_half <= ~step_half;
            step_tick <= !click_reg[CK_RATE_BIT] || step_half;
         end else begin
            step_cnt <= step_cnt + 12'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         volume_reg <= {1'b1, VOL_RST};
      end else if (wr_hit && avs_address == ADDR_VOLUME && avs_byteenable[0]) begin
         volume_reg <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gain_level         <= 7'h0;
         gain_zero_out      <= 1'b1;
         softstep_done_flag <= 1'b1;
      end else begin
         softstep_done_flag <= (gain_level == gain_target);
         if (step_tick && gain_level < gain_target) gain_level <= gain_level + 7'h1;
         if (step_tick && gain_level > gain_target) gain_level <= gain_level - 7'h1;
         // zeros only once fully down, so the mute lands without a pop
         gain_zero_out <= volume_reg[7] && (gain_level == 7'h0);
      end
   end

   // ---------------- power control ----------------
   logic [6:0]  sect_req;
   logic [10:0] seq_cnt;
   logic        vcm_need;
   logic        vcm_latched;
   logic [27:0] vcm_cnt;
   logic        vcm_settled;

   always_ff @(posedge clk) begin
      if (srst) begin
         power_reg <= {PW_HIGH_RST, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'b000};
      end else if (wr_hit && avs_address == ADDR_POWER) begin
         if (avs_byteenable[1]) power_reg[15:8] <= wdata[15:8];
         if (avs_byteenable[0]) power_reg[7:0] <= wdata[7:0] & PW_WMASK[7:0];
      end
   end

   // index: 0 bypass, 1 headphone, 2 mono, 3 out conv, 4 in conv, 5 input front end, 6 vcm
   always_comb begin
      sect_req[0] = !power_reg[PW_BYPASS_BIT];
      sect_req[1] = !power_reg[PW_HP_BIT];
      sect_req[2] = !power_reg[PW_MONO_BIT];
      sect_req[3] = !power_reg[PW_DAC_BIT];
      sect_req[4] = !power_reg[PW_ADC_BIT];
      sect_req[5] = sect_req[2] || sect_req[4];
      sect_req[6] = vcm_need || vcm_latched;
      if (power_reg[PW_MASTER_BIT]) sect_req = 7'h0;
   end

   assign vcm_need = !power_reg[PW_BYPASS_BIT] || !power_reg[PW_DAC_BIT] || !power_reg[PW_ADC_BIT];

   always_ff @(posedge clk) begin
      if (srst) begin
         vcm_latched <= 1'b0;
      end else if (power_reg[PW_VCM_BIT]) begin
         vcm_latched <= 1'b0;
      end else if (common_mode_reference) begin
         vcm_latched <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         section_power_on         <= 7'h0;
         common_mode_reference    <= 1'b0;
         seq_cnt                  <= 11'h0;
         vcm_cnt                  <= 28'h0;
         vcm_settled              <= 1'b0;
         power_sequence_done_flag <= 1'b1;
      end else begin
         common_mode_reference <= sect_req[6];
         // pending sections 0 to 5 switch together after one settling interval; section 6 follows the vcm ramp
         if (power_reg[PW_MASTER_BIT]) begin
            // master cuts everything at once; otherwise power-up and power-down both wait for settling
            seq_cnt               <= 11'h0;
            section_power_on[5:0] <= 6'h00;
         end else if (section_power_on[5:0] != sect_req[5:0]) begin
            if (seq_cnt == 11'(SECTION_CYC - 1)) begin
               seq_cnt          <= 11'h0;
               section_power_on <= {section_power_on[6], sect_req[5:0]};
            end else begin
               seq_cnt <= seq_cnt + 11'h1;
            end
         end
         if (!sect_req[6]) begin
            vcm_cnt     <= 28'h0;
            vcm_settled <= 1'b0;
            section_power_on[6] <= 1'b0;
         end else if (vcm_cnt == 28'(VCM_RAMP_CYCLES - 1)) begin
            vcm_settled <= 1'b1;
            section_power_on[6] <= 1'b1;
         end else begin
            vcm_cnt <= vcm_cnt + 28'h1;
         end
         power_sequence_done_flag <= (section_power_on[5:0] == sect_req[5:0])
                                     && (vcm_settled == sect_req[6]);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mic_bias_on         <= 1'b0;
         crystal_osc_on      <= 1'b1;
         osc_clock_buffer_on <= 1'b0;
         sync_monitor_on     <= 1'b0;
         bass_filter_on      <= 1'b0;
         deemphasis_on       <= 1'b0;
      end else begin
         mic_bias_on         <= !power_reg[PW_MICB_BIT] && !power_reg[PW_MASTER_BIT];
         crystal_osc_on      <= power_reg[PW_OSC_BIT];
         osc_clock_buffer_on <= power_reg[PW_CLKBUF_BIT] && power_reg[PW_OSC_BIT];
         sync_monitor_on     <= !power_reg[PW_SMON_BIT];
         bass_filter_on      <= power_reg[PW_BASS_BIT];
         deemphasis_on       <= power_reg[PW_DEEMP_BIT];
      end
   end

   // ---------------- serial audio sync ----------------
   always_ff @(posedge clk) begin
      if (srst) begin
         unsync_sync_reg <= 2'b00;
      end else begin
         unsync_sync_reg <= {unsync_sync_reg[0], bus_unsync_in};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         serial_audio_unsync_flag <= 1'b1;
         converters_halted        <= 1'b0;
      end else begin
         converters_halted <= sync_monitor_on && unsync_sync_reg[1];
         // set wins over the clear-on-read
         if (sync_monitor_on && unsync_sync_reg[1]) begin
            serial_audio_unsync_flag <= 1'b1;
         end else if (rd_hit && avs_address == ADDR_POWER) begin
            serial_audio_unsync_flag <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/audio_keyclick_power_control_checker.sv
// checker: port-level assertions for the audio control bank
`timescale 1ns/1ps
`default_nettype none
module audio_keyclick_power_control_checker
   import audio_ctrl_pkg::*;
#(
   parameter int VCM_RAMP_CYCLES = 20
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        click_active,
   input wire logic        mono_source_select,
   input wire logic [6:0]  gain_level,
   input wire logic        gain_zero_out,
   input wire logic [6:0]  section_power_on,
   input wire logic        mic_bias_on,
   input wire logic        crystal_osc_on
);
   logic        wr_done;
   logic [15:0] wd_q;
   assign wr_done = avs_write && !avs_waitrequest;
   // keep the accepted data so later cycles can compare against it
   always_ff @(posedge clk) begin
      if (wr_done) wd_q <= avs_writedata[15:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_ack_bounded: assert property ((avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
      else $error("request not answered in time");
   a_upper_zero: assert property (avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_master_off: assert property (wr_done && avs_address == ADDR_POWER && avs_byteenable[1]
      && avs_writedata[PW_MASTER_BIT] |-> ##[1:3] section_power_on[5:0] == 6'h00)
      else $error("master power-down left a section on");
   a_mic_bias: assert property (wr_done && avs_address == ADDR_POWER && avs_byteenable[0]
      && avs_byteenable[1] && !avs_writedata[PW_MASTER_BIT]
      |=> ##[0:2] mic_bias_on == !wd_q[PW_MICB_BIT])
      else $error("mic bias does not follow its bit");
   a_osc_enable: assert property (wr_done && avs_address == ADDR_POWER && avs_byteenable[0]
      |=> ##[0:2] crystal_osc_on == wd_q[PW_OSC_BIT])
      else $error("oscillator does not follow its bit");
   a_mono_select: assert property (wr_done && avs_address == ADDR_CLICK && avs_byteenable[0]
      |=> ##[0:2] mono_source_select == wd_q[CK_MONO_BIT])
      else $error("mono select does not follow its bit");
   a_click_start: assert property (wr_done && avs_address == ADDR_CLICK && avs_byteenable[1]
      && avs_writedata[CK_TRIG_BIT] |-> ##[1:4] click_active)
      else $error("trigger write did not start a burst");
   a_zero_floor: assert property (gain_zero_out |-> gain_level == 7'h00)
      else $error("zeros sent before gain reached floor");
endmodule
bind audio_keyclick_power_control audio_keyclick_power_control_checker
   #(.VCM_RAMP_CYCLES(VCM_RAMP_CYCLES)) u_chk (.clk(clk), .srst(srst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .click_active(click_active), .mono_source_select(mono_source_select),
   .gain_level(gain_level), .gain_zero_out(gain_zero_out),
   .section_power_on(section_power_on), .mic_bias_on(mic_bias_on),
   .crystal_osc_on(crystal_osc_on));
`default_nettype wire

// ===== dv/audio_keyclick_power_control_tb_top.sv
// testbench: register-level tests for the audio control bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
`define WAIT_UNTIL(c, lim) begin n = 0; while (!(c) && n < lim) begin @(negedge clk); n++; end end
module audio_keyclick_power_control_tb_top
   import audio_ctrl_pkg::*;
;
   int          num_errors = 0;
   int          comparisons = 0;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h3;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        bus_unsync_in = 1'b0;
   logic        click_active, click_wave, mono_source_select, gain_zero_out;
   logic [2:0]  click_amplitude;
   logic [6:0]  gain_level, section_power_on;
   logic        common_mode_reference, mic_bias_on, crystal_osc_on;

   always #2.5 clk = ~clk;

   audio_keyclick_power_control #(.VCM_RAMP_CYCLES(20)) dut (.clk(clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_unsync_in(bus_unsync_in), .click_active(click_active), .click_wave(click_wave),
      .click_amplitude(click_amplitude), .mono_source_select(mono_source_select),
      .gain_level(gain_level), .gain_zero_out(gain_zero_out),
      .section_power_on(section_power_on), .common_mode_reference(common_mode_reference),
      .mic_bias_on(mic_bias_on), .crystal_osc_on(crystal_osc_on), .osc_clock_buffer_on(),
      .sync_monitor_on(), .converters_halted(), .bass_filter_on(), .deemphasis_on());

   task automatic tally_and_finish();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // values read right after the edge are the ones that edge sampled
   task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [15:0] wdata,
                           output logic [15:0] rdata);
      int   k = 0;
      @(posedge clk);
      avs_address   <= addr;
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_writedata <= {16'h0000, wdata};
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest && k < 50);
      `CHK(avs_waitrequest, 1'b0)
      rdata = avs_readdata[15:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] addr, input logic [15:0] data);
      logic [15:0] r;
      bus_xfer(1'b1, addr, data, r);
   endtask

   task automatic rd_chk(input logic [3:0] addr, input logic [15:0] exp, input logic [15:0] mask);
      logic [15:0] r;
      bus_xfer(1'b0, addr, 16'h0000, r);
      `CHK(r & mask, exp)
   endtask

   task automatic wait_power_done();
      logic [15:0] r;
      int          k = 0;
      do begin
         repeat (200) @(posedge clk);
         bus_xfer(1'b0, ADDR_POWER, 16'h0000, r);
         k++;
      end while (!r[PW_DONE_BIT] && k < 200);
      `CHK(r[PW_DONE_BIT], 1'b1)
   endtask

   initial begin
      int n;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd_chk(ADDR_CLICK, 16'h4411, 16'hFFFF);
      rd_chk(ADDR_POWER, 16'hFFA4, 16'hFFFF);
      rd_chk(ADDR_POWER, 16'hFFA0, 16'hFFFF);
      rd_chk(4'h3, 16'h0000, 16'hFFFF);
      wr(4'h3, 16'hFFFF);
      rd_chk(ADDR_CLICK, 16'h4411, 16'hFFFF);
      bus_unsync_in <= 1'b1;
      repeat (4) @(posedge clk);
      bus_unsync_in <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(ADDR_POWER, 16'h0004, 16'h0004);
      rd_chk(ADDR_POWER, 16'h0000, 16'h0004);
      // fastest tone, shortest length: two periods of 25000 cycles
      wr(ADDR_CLICK, 16'hFF0C);
      rd_chk(ADDR_CLICK, 16'hF705, 16'hFFFF);
      `CHK(click_amplitude, 3'h7)
      `CHK(mono_source_select, 1'b1)
      `WAIT_UNTIL(!click_active, 60000)
      `CHK(n > 49800 && n < 50100, 1'b1)
      rd_chk(ADDR_CLICK, 16'h7705, 16'hFFFF);
      wr(ADDR_VOLUME, 16'h0002);
      rd_chk(ADDR_CLICK, 16'h0000, 16'h0001);
      `WAIT_UNTIL(gain_level === 7'h02, 20000)
      `CHK(n > 3900 && n < 8200, 1'b1)
      repeat (10) @(posedge clk);
      rd_chk(ADDR_CLICK, 16'h0001, 16'h0001);
      wr(ADDR_CLICK, 16'h4412);
      wr(ADDR_VOLUME, 16'h0082);
      `WAIT_UNTIL(gain_zero_out === 1'b1, 30000)
      `CHK(n > 7900 && n < 16400, 1'b1)
      wr(ADDR_CLICK, 16'h4410);
      wr(ADDR_VOLUME, 16'h0002);
      `WAIT_UNTIL(gain_level === 7'h02, 30000)
      `CHK(gain_zero_out, 1'b0)
      wr(ADDR_POWER, 16'h7D20);
      rd_chk(ADDR_POWER, 16'h0000, 16'h0080);
      wait_power_done();
      `CHK(section_power_on[5:2], 4'b1100)
      `CHK({mic_bias_on, crystal_osc_on}, 2'b11)
      wr(ADDR_POWER, 16'h7720);
      wait_power_done();
      `CHK(section_power_on[5:2], 4'b1001)
      wr(ADDR_POWER, 16'h4B20);
      wait_power_done();
      `CHK(section_power_on[3:0], 4'b1011)
      `CHK(common_mode_reference, 1'b1)
      wr(ADDR_POWER, 16'hCB40);
      wait_power_done();
      `CHK(section_power_on[5:0], 6'h00)
      `CHK({mic_bias_on, crystal_osc_on}, 2'b00)
      rd_chk(ADDR_POWER, 16'hCB40, 16'hFF7B);
      wr(ADDR_POWER, 16'h4B20);
      wait_power_done();
      `CHK(section_power_on[3:0], 4'b1011)
      tally_and_finish();
   end

   initial begin
      #(5 * 120000);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
